// *** shared/upper_bank_pkg.sv ***
// constants for the upper special register bank and its bus front end
package upper_bank_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned AXI_ADDR_W = 10;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned RAM_DEPTH = 256;
  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INDIRECT = 8'h80;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PC_LOW = 8'h82;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_POINTER = 8'h84;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_B = 8'h86;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_PC_LATCH = 8'h8A;
  localparam logic [7:0] IDX_INT_CTL = 8'h8B;
  localparam logic [7:0] IDX_IRQE = 8'h8C;
  localparam logic [7:0] IDX_PWR = 8'h8E;
  localparam logic [7:0] IDX_T2P = 8'h92;
  localparam logic [7:0] IDX_SADDR = 8'h93;
  localparam logic [7:0] IDX_SSTAT = 8'h94;
  localparam logic [7:0] IDX_ACFG = 8'h9F;
  localparam logic [7:0] IDX_BANK1 = 8'h80;
  localparam logic [7:0] IDX_LAST = 8'h9F;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [5:0] RST_DIR_A = 6'h3F;
  localparam logic [7:0] RST_DIR_B = 8'hFF;
  localparam logic [7:0] RST_DIR_C = 8'hFF;
  localparam logic [7:0] RST_T2P = 8'hFF;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] IRQE_MASK = 8'h4F;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned PWR_POR = 1;
  localparam int unsigned PWR_BOR = 0;
  localparam int unsigned INT_KEPT = 0;
  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** shared/reg_access_if.sv ***
// byte wide write and read access between blocks
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wdata;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  modport requester (output wr_en, output wr_addr, output wdata,
                     output rd_addr, input rdata);
  modport responder (input wr_en, input wr_addr, input wdata,
                     input rd_addr, output rdata);
endinterface
`default_nettype wire

// *** rtl/data_memory.sv ***
// data memory reached through the indirect slot
`timescale 1ns/1ps
`default_nettype none
module data_memory #(
  parameter int unsigned DEPTH = upper_bank_pkg::RAM_DEPTH
) (
  input wire logic clock,
  reg_access_if.responder mem
);
  import upper_bank_pkg::*;
  logic [7:0] store [DEPTH];
  // ----------------------------------------------------------------
  // storage, no reset: contents unknown after power-up
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (mem.wr_en) begin
      store[mem.wr_addr] <= mem.wdata;
    end
  end
  assign mem.rdata = store[mem.rd_addr];
endmodule // data_memory
`default_nettype wire

// *** rtl/axi_reg_slave.sv ***
// axi4-lite slave that turns bus words into byte register accesses
`timescale 1ns/1ps
`default_nettype none
module axi_reg_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic [upper_bank_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [upper_bank_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_access_if.requester regs
);
  import upper_bank_pkg::*;
  typedef struct packed {
    logic have_aw;
    logic have_w;
    logic [7:0] widx;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slave_state_t;
  localparam slave_state_t SLAVE_RESET = '{default: '0};
  slave_state_t q, d;
  logic [7:0] ridx;
  logic fire;
  // ----------------------------------------------------------------
  // channel handling
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ridx = araddr[IDX_LSB +: IDX_W];
    fire = q.have_aw & q.have_w & ~q.bvalid;
    if (awvalid & q.awready) begin
      d.have_aw = 1'b1;
      d.widx = awaddr[IDX_LSB +: IDX_W];
    end
    if (wvalid & q.wready) begin
      d.have_w = 1'b1;
      d.wbyte = wdata[DATA_W-1:0];
      d.wlane = wstrb[0];
    end
    if (fire) begin
      d.have_aw = 1'b0;
      d.have_w = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (q.widx > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
    end
    if (q.bvalid & bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid & q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = {{(AXI_DATA_W-DATA_W){1'b0}}, regs.rdata};
      d.rresp = (ridx > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
    end else if (q.rvalid & rready) begin
      d.rvalid = 1'b0;
    end
    d.awready = ~d.have_aw & ~d.bvalid;
    d.wready = ~d.have_w & ~d.bvalid;
    d.arready = ~d.rvalid;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= SLAVE_RESET;
    end else begin
      q <= d;
    end
  end
  assign regs.wr_en = fire & q.wlane & (q.widx <= IDX_LAST);
  assign regs.wr_addr = q.widx;
  assign regs.wdata = q.wbyte;
  assign regs.rd_addr = ridx;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule // axi_reg_slave
`default_nettype wire

// *** rtl/upper_bank_special_registers.sv ***
// upper special register bank with mirrored core registers and resets
`timescale 1ns/1ps
`default_nettype none
// Function
// - unimplemented addresses in the bank read zero and ignore writes
// - master clear or watchdog reset loads each register with its other-reset value; brown-out loads power-on values
// - unchanged bits survive other resets; unknown bits are given zero at power-on
// - power cause bits reset by reset kind: power-on versus brown-out
// - port b direction resets to all ones; each bit steers one pin
// - port c direction resets to all ones; each bit steers one pin
// - mirrored core registers decode from either bank to one storage
// - pc latch holds pc bits 12..8, copied into hidden upper pc byte
// - master clear pin and watchdog timeout count as other resets
module upper_bank_special_registers (
  input wire logic clock,
  input wire logic rst,
  input wire logic brownout_detect,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timeout,
  input wire logic [5:0] serial_state_in,
  input wire logic [upper_bank_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [upper_bank_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] timer0_pullup_edge_config,
  output logic [7:0] prog_counter_low,
  output logic [4:0] prog_counter_upper,
  output logic [7:0] core_status_flags,
  output logic [7:0] indirect_pointer,
  output logic [5:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic [4:0] prog_counter_high_latch,
  output logic [7:0] interrupt_control,
  output logic [7:0] peripheral_irq_enable_1,
  output logic [1:0] power_reset_cause,
  output logic [7:0] timer2_period,
  output logic [7:0] serial_slave_address,
  output logic [2:0] analog_pin_config
);
  import upper_bank_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clear_sync;
    logic clear_low;
    logic [7:0] option;
    logic [7:0] pc_low;
    logic [4:0] pc_upper;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [5:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [4:0] pc_latch;
    logic [7:0] int_ctl;
    logic [7:0] irqe;
    logic [1:0] pwr;
    logic [7:0] t2p;
    logic [7:0] saddr;
    logic [5:0] sstat;
    logic [2:0] acfg;
  } bank_state_t;

  // power-on values; unknown bits are given zero here
  localparam bank_state_t POWER_ON = '{
    clear_sync: 3'h7,
    clear_low: 1'b0,
    option: RST_OPTION,
    pc_low: 8'h00,
    pc_upper: 5'h00,
    status: RST_STATUS,
    pointer: 8'h00,
    dir_a: RST_DIR_A,
    dir_b: RST_DIR_B,
    dir_c: RST_DIR_C,
    pc_latch: 5'h00,
    int_ctl: 8'h00,
    irqe: 8'h00,
    pwr: 2'h0,
    t2p: RST_T2P,
    saddr: 8'h00,
    sstat: 6'h00,
    acfg: 3'h0
  };

  bank_state_t q, d;
  logic other_reset;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic ptr_to_slot;

  reg_access_if bus ();
  reg_access_if mem ();

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  axi_reg_slave u_slave (
    .clock(clock),
    .rst(rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .regs(bus.requester)
  );

  data_memory #(
    .DEPTH(RAM_DEPTH)
  ) u_memory (
    .clock(clock),
    .mem(mem.responder)
  );

  // ----------------------------------------------------------------
  // address folding
  // ----------------------------------------------------------------
  function automatic logic [7:0] fold(input logic [7:0] idx);
    logic [7:0] up;
    up = idx | IDX_BANK1;
    fold = idx;
    if (idx < IDX_BANK1) begin
      fold = 8'hFF;
      if (up == IDX_INDIRECT || up == IDX_PC_LOW || up == IDX_STATUS ||
          up == IDX_POINTER || up == IDX_PC_LATCH ||
          up == IDX_INT_CTL) begin
        fold = up;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    wr_idx = fold(bus.wr_addr);
    rd_idx = fold(bus.rd_addr);
    ptr_to_slot = (fold(q.pointer) == IDX_INDIRECT);
    mem.wr_en = 1'b0;
    mem.wr_addr = q.pointer;
    mem.wdata = bus.wdata;
    mem.rd_addr = q.pointer;
    // pin passes three stages; level counts once stages two and three agree
    d.clear_sync = {q.clear_sync[1:0], master_clear_pin_n};
    if (q.clear_sync[1] == q.clear_sync[2]) begin
      d.clear_low = ~q.clear_sync[2];
    end
    d.sstat = serial_state_in;
    other_reset = q.clear_low | watchdog_timeout;
    if (brownout_detect) begin
      d = POWER_ON;
      d.clear_sync = {q.clear_sync[1:0], master_clear_pin_n};
      d.clear_low = q.clear_low;
      d.pwr[PWR_POR] = q.pwr[PWR_POR];
      d.pwr[PWR_BOR] = 1'b0;
    end else if (other_reset) begin
      d.option = RST_OPTION;
      d.pc_low = 8'h00;
      d.pc_upper = 5'h00;
      d.status[7:5] = 3'h0;
      if (watchdog_timeout) begin
        d.status[ST_TO] = 1'b0;
      end
      d.dir_a = RST_DIR_A;
      d.dir_b = RST_DIR_B;
      d.dir_c = RST_DIR_C;
      d.pc_latch = 5'h00;
      d.int_ctl[7:1] = 7'h00;
      d.irqe = 8'h00;
      d.t2p = RST_T2P;
      d.saddr = 8'h00;
      d.sstat = 6'h00;
      d.acfg = 3'h0;
      // pointer, status low bits, pwr and int flag kept
    end else if (bus.wr_en) begin
      case (wr_idx)
        IDX_INDIRECT: begin
          mem.wr_en = ~ptr_to_slot;
        end
        IDX_OPTION: begin
          d.option = bus.wdata;
        end
        IDX_PC_LOW: begin
          d.pc_low = bus.wdata;
          d.pc_upper = q.pc_latch;
        end
        IDX_STATUS: begin
          d.status = {bus.wdata[7:5], q.status[ST_TO:ST_PD],
                      bus.wdata[2:0]};
        end
        IDX_POINTER: begin
          d.pointer = bus.wdata;
        end
        IDX_DIR_A: begin
          d.dir_a = bus.wdata[5:0];
        end
        IDX_DIR_B: begin
          d.dir_b = bus.wdata;
        end
        IDX_DIR_C: begin
          d.dir_c = bus.wdata;
        end
        IDX_PC_LATCH: begin
          d.pc_latch = bus.wdata[4:0];
        end
        IDX_INT_CTL: begin
          d.int_ctl = bus.wdata;
        end
        IDX_IRQE: begin
          d.irqe = bus.wdata & IRQE_MASK;
        end
        IDX_PWR: begin
          d.pwr = bus.wdata[1:0];
        end
        IDX_T2P: begin
          d.t2p = bus.wdata;
        end
        IDX_SADDR: begin
          d.saddr = bus.wdata;
        end
        IDX_ACFG: begin
          d.acfg = bus.wdata[2:0];
        end
        default: begin
          d.option = q.option;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    case (rd_idx)
      IDX_INDIRECT: begin
        rd_val = ptr_to_slot ? 8'h00 : mem.rdata;
      end
      IDX_OPTION: begin
        rd_val = q.option;
      end
      IDX_PC_LOW: begin
        rd_val = q.pc_low;
      end
      IDX_STATUS: begin
        rd_val = q.status;
      end
      IDX_POINTER: begin
        rd_val = q.pointer;
      end
      IDX_DIR_A: begin
        rd_val = {2'h0, q.dir_a};
      end
      IDX_DIR_B: begin
        rd_val = q.dir_b;
      end
      IDX_DIR_C: begin
        rd_val = q.dir_c;
      end
      IDX_PC_LATCH: begin
        rd_val = {3'h0, q.pc_latch};
      end
      IDX_INT_CTL: begin
        rd_val = q.int_ctl;
      end
      IDX_IRQE: begin
        rd_val = q.irqe;
      end
      IDX_PWR: begin
        rd_val = {6'h00, q.pwr};
      end
      IDX_T2P: begin
        rd_val = q.t2p;
      end
      IDX_SADDR: begin
        rd_val = q.saddr;
      end
      IDX_SSTAT: begin
        rd_val = {2'h0, q.sstat};
      end
      IDX_ACFG: begin
        rd_val = {5'h00, q.acfg};
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end
  assign bus.rdata = rd_val;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= POWER_ON;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign timer0_pullup_edge_config = q.option;
  assign prog_counter_low = q.pc_low;
  assign prog_counter_upper = q.pc_upper;
  assign core_status_flags = q.status;
  assign indirect_pointer = q.pointer;
  assign port_a_direction = q.dir_a;
  assign port_b_direction = q.dir_b;
  assign port_c_direction = q.dir_c;
  assign prog_counter_high_latch = q.pc_latch;
  assign interrupt_control = q.int_ctl;
  assign peripheral_irq_enable_1 = q.irqe;
  assign power_reset_cause = q.pwr;
  assign timer2_period = q.t2p;
  assign serial_slave_address = q.saddr;
  assign analog_pin_config = q.acfg;
endmodule // upper_bank_special_registers
`default_nettype wire

// *** bench/upper_bank_assertions.sv ***
// protocol and reset checks for the upper special register bank
`timescale 1ns/1ps
`default_nettype none
module upper_bank_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic [upper_bank_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] timer0_pullup_edge_config,
  input wire logic [7:0] prog_counter_low,
  input wire logic [4:0] prog_counter_upper,
  input wire logic [7:0] core_status_flags,
  input wire logic [7:0] indirect_pointer,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_c_direction,
  input wire logic [4:0] prog_counter_high_latch,
  input wire logic [1:0] power_reset_cause,
  input wire logic [7:0] timer2_period
);
  import upper_bank_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  function automatic logic void_idx(input logic [7:0] i);
    return (i inside {8'h88, 8'h89, 8'h8D, [8'h8F:8'h91], [8'h95:8'h9E]})
      || (i > IDX_LAST);
  endfunction
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_dir_b_reset: assert property (
    $fell(rst) |-> port_b_direction == RST_DIR_B)
    else $error("port b direction not all ones after reset");
  a_dir_c_reset: assert property (
    $fell(rst) |-> port_c_direction == RST_DIR_C)
    else $error("port c direction not all ones after reset");
  a_por_values: assert property (
    $fell(rst) |-> timer0_pullup_edge_config == RST_OPTION
      && core_status_flags == RST_STATUS && timer2_period == RST_T2P
      && power_reset_cause == 2'h0)
    else $error("power-on values wrong");
  a_brownout_cause: assert property (
    brownout_detect |=> !power_reset_cause[PWR_BOR]
      && power_reset_cause[PWR_POR] == $past(power_reset_cause[PWR_POR]))
    else $error("brown-out cause flags wrong");
  a_watchdog_other: assert property (
    watchdog_timeout && !brownout_detect |=>
      timer0_pullup_edge_config == RST_OPTION
      && port_b_direction == RST_DIR_B && !core_status_flags[ST_TO])
    else $error("watchdog reset values wrong");
  a_other_keep: assert property (
    watchdog_timeout && !brownout_detect |=>
      $stable(power_reset_cause) && $stable(indirect_pointer)
      && $stable(core_status_flags[ST_PD:0]))
    else $error("unchanged bits lost on other reset");
  a_pc_upper_load: assert property (
    $rose(s_axi_bvalid) && $changed(prog_counter_low)
      && !$past(watchdog_timeout) && !$past(brownout_detect)
      |-> prog_counter_upper == $past(prog_counter_high_latch))
    else $error("upper pc not loaded from latch");
  a_void_read_zero: assert property (
    $rose(s_axi_rvalid) && void_idx($past(s_axi_araddr[9:2]))
      |-> s_axi_rdata == 32'h0)
    else $error("unimplemented location read nonzero");
  a_read_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_slverr: cover property ($rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR);
  c_watchdog: cover property (watchdog_timeout);
  c_brownout: cover property (brownout_detect);
endmodule // upper_bank_assertions
bind upper_bank_special_registers upper_bank_assertions u_upper_bank_assertions (
  .clock(clock), .rst(rst), .brownout_detect(brownout_detect),
  .watchdog_timeout(watchdog_timeout), .s_axi_araddr(s_axi_araddr),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp),
  .timer0_pullup_edge_config(timer0_pullup_edge_config),
  .prog_counter_low(prog_counter_low),
  .prog_counter_upper(prog_counter_upper),
  .core_status_flags(core_status_flags),
  .indirect_pointer(indirect_pointer),
  .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction),
  .prog_counter_high_latch(prog_counter_high_latch),
  .power_reset_cause(power_reset_cause), .timer2_period(timer2_period));
`default_nettype wire

// *** bench/test_upper_bank_special_registers.sv ***
// self-checking bench for the upper special register bank
`timescale 1ns/1ps
`default_nettype none
module test_upper_bank_special_registers;
  import upper_bank_pkg::*;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  logic clock, rst, brownout_detect, master_clear_pin_n, watchdog_timeout;
  logic [5:0] serial_state_in;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] dirb, dirc;
  logic [4:0] pcu;
  logic [7:0] ien;
  logic [2:0] acfg;
  int bad_count, tests_run, i;
  logic [7:0] ri [15] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
    8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h92, 8'h93, 8'h94, 8'h9F};
  logic [7:0] rv [15] = '{8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h2A, 8'h00};
  logic [7:0] ui [17] = '{8'h88, 8'h89, 8'h8D, 8'h8F, 8'h90, 8'h91, 8'h95,
    8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h05};
  upper_bank_special_registers u_upper_bank_special_registers (
    .clock(clock), .rst(rst), .brownout_detect(brownout_detect),
    .master_clear_pin_n(master_clear_pin_n),
    .watchdog_timeout(watchdog_timeout), .serial_state_in(serial_state_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_pullup_edge_config(), .prog_counter_low(),
    .prog_counter_upper(pcu), .core_status_flags(), .indirect_pointer(),
    .port_a_direction(), .port_b_direction(dirb), .port_c_direction(dirc),
    .prog_counter_high_latch(), .interrupt_control(),
    .peripheral_irq_enable_1(ien), .power_reset_cause(), .timer2_period(),
    .serial_slave_address(), .analog_pin_config(acfg));
  always #10 clock = ~clock;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge clock);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awready && awvalid) awvalid <= 1'h0;
      if (wready && wvalid) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (n == 40) begin
      bad_count++;
      end_sim();
    end
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                     input logic [1:0] er);
    int n;
    @(posedge clock);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arready && arvalid) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (n == 40) begin
      bad_count++;
      end_sim();
    end
    rready <= 1'h0;
    check(rdata, {24'h0, exp});
    check({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic pulse_wd(input logic bo);
    @(posedge clock);
    if (bo) brownout_detect <= 1'h1;
    else watchdog_timeout <= 1'h1;
    @(posedge clock);
    brownout_detect <= 1'h0;
    watchdog_timeout <= 1'h0;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim();
  end
  initial begin
    clock = 1'h0;
    rst = 1'h1;
    {brownout_detect, watchdog_timeout, awvalid, wvalid, bready} = 5'h0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    master_clear_pin_n = 1'h1;
    serial_state_in = 6'h2A;
    wstrb = 4'hF;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    check(dirb, 8'hFF);
    check(dirc, 8'hFF);
    for (i = 0; i < 15; i++) rdc(ri[i], rv[i], RESP_OKAY);
    for (i = 0; i < 17; i++) begin
      wr(ui[i], 8'hFF, RESP_OKAY);
      rdc(ui[i], 8'h00, RESP_OKAY);
    end
    wr(8'hA0, 8'h55, RESP_SLVERR);
    rdc(8'hA0, 8'h00, RESP_SLVERR);
    wr(8'h86, 8'hA5, RESP_OKAY);
    check(dirb, 8'hA5);
    wr(8'h87, 8'h5A, RESP_OKAY);
    check(dirc, 8'h5A);
    wr(8'h04, 8'h3C, RESP_OKAY);
    rdc(8'h84, 8'h3C, RESP_OKAY);
    wr(8'h0B, 8'hF1, RESP_OKAY);
    rdc(8'h8B, 8'hF1, RESP_OKAY);
    wr(8'h0A, 8'h15, RESP_OKAY);
    rdc(8'h8A, 8'h15, RESP_OKAY);
    wr(8'h03, 8'h27, RESP_OKAY);
    rdc(8'h83, 8'h3F, RESP_OKAY);
    wr(8'h02, 8'h33, RESP_OKAY);
    check({27'h0, pcu}, 32'h15);
    wr(8'h80, 8'h6B, RESP_OKAY);
    rdc(8'h00, 8'h6B, RESP_OKAY);
    wr(8'h84, 8'h40, RESP_OKAY);
    wr(8'h80, 8'h11, RESP_OKAY);
    rdc(8'h80, 8'h11, RESP_OKAY);
    wr(8'h04, 8'h3C, RESP_OKAY);
    rdc(8'h80, 8'h6B, RESP_OKAY);
    wr(8'h8E, 8'h03, RESP_OKAY);
    wr(8'h81, 8'h12, RESP_OKAY);
    wr(8'h8C, 8'hFF, RESP_OKAY);
    wr(8'h9F, 8'hFF, RESP_OKAY);
    check({24'h0, ien}, 32'h4F);
    check({29'h0, acfg}, 32'h7);
    rdc(8'h8C, 8'h4F, RESP_OKAY);
    pulse_wd(1'h0);
    rdc(8'h81, 8'hFF, RESP_OKAY);
    rdc(8'h86, 8'hFF, RESP_OKAY);
    rdc(8'h84, 8'h3C, RESP_OKAY);
    rdc(8'h83, 8'h0F, RESP_OKAY);
    rdc(8'h8B, 8'h01, RESP_OKAY);
    rdc(8'h8E, 8'h03, RESP_OKAY);
    check({24'h0, ien}, 32'h0);
    check({29'h0, acfg}, 32'h0);
    wr(8'h81, 8'h12, RESP_OKAY);
    master_clear_pin_n <= 1'h0;
    repeat (8) @(posedge clock);
    master_clear_pin_n <= 1'h1;
    repeat (8) @(posedge clock);
    rdc(8'h81, 8'hFF, RESP_OKAY);
    rdc(8'h83, 8'h0F, RESP_OKAY);
    pulse_wd(1'h1);
    rdc(8'h8E, 8'h02, RESP_OKAY);
    rdc(8'h83, 8'h18, RESP_OKAY);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    rdc(8'h8E, 8'h00, RESP_OKAY);
    end_sim();
  end
endmodule // test_upper_bank_special_registers
`default_nettype wire
